// File: core/scg_clk_if.sv
// Clock bundle passed from the duty stage through the divider to the top
`timescale 1ns/10ps
interface scg_clk_if;
    logic sysclk;
    logic sysclk_rise;
    logic fast;
    logic run;
    logic [4:0] div;

    modport duty
    (
        output sysclk,
        output sysclk_rise,
        output fast
    );
    modport divider
    (
        input sysclk_rise,
        input run,
        output div
    );
    modport top
    (
        input sysclk,
        input sysclk_rise,
        input fast,
        input div,
        output run
    );
endinterface

// File: core/scg_divider.sv
// Divider producing the five medium-speed clocks
`timescale 1ns/10ps
module scg_divider
    import scg_pkg::*;
(
    input wire logic core_clk, // System clock of the logic
    input wire logic reset, // Synchronous reset, active high
    scg_clk_if.divider clk_bus // System clock edge in, divided clocks out
);
    logic [SCG_NDIV-1:0] cnt_ff;

    // Ripple count gives /2 up to /32
    always_ff @(posedge core_clk)
    begin
        if (reset)
            cnt_ff <= '0;
        else if (clk_bus.run && clk_bus.sysclk_rise)
            cnt_ff <= cnt_ff + 5'h01;
    end

    assign clk_bus.div = cnt_ff;

    a_div_counts: assert property (@(posedge core_clk) disable iff (reset)
        (clk_bus.run && clk_bus.sysclk_rise) |=> cnt_ff == $past(cnt_ff) + 5'h01)
        else $error("divider did not advance on system clock edge");
endmodule

// File: core/scg_duty.sv
// Duty correction of the oscillator into the system clock
`timescale 1ns/10ps
module scg_duty
    import scg_pkg::*;
(
    input wire logic core_clk, // System clock of the logic
    input wire logic reset, // Synchronous reset, active high
    input wire logic osc_clk, // Oscillator or external clock level
    scg_clk_if.duty clk_bus // Regenerated system clock out
);
    logic osc_q_ff;
    logic [SCG_PER_W-1:0] per_cnt_ff;
    logic [SCG_PER_W-1:0] period_ff;
    logic [SCG_PER_W-1:0] high_left_ff;
    logic corr_ff;
    logic sysclk_ff;
    logic rise_ff;
    logic osc_rise;
    logic nxt_sysclk;

    assign osc_rise = osc_clk & ~osc_q_ff;

    always_ff @(posedge core_clk)
    begin
        if (reset)
            osc_q_ff <= 1'b0;
        else
            osc_q_ff <= osc_clk;
    end

    // Saturating period measure, rising edge to rising edge
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            per_cnt_ff <= '0;
            period_ff <= SCG_PER_MAX;
        end
        else if (osc_rise)
        begin
            per_cnt_ff <= 8'h01;
            period_ff <= per_cnt_ff;
        end
        else if (per_cnt_ff != SCG_PER_MAX)
            per_cnt_ff <= per_cnt_ff + 8'h01;
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            corr_ff <= 1'b0;
            high_left_ff <= '0;
        end
        else if (osc_rise)
        begin
            corr_ff <= 1'b1;
            high_left_ff <= {1'b0, period_ff[SCG_PER_W-1:1]};
        end
        else if (high_left_ff > 8'h01)
            high_left_ff <= high_left_ff - 8'h01;
        else
        begin
            high_left_ff <= '0;
            corr_ff <= 1'b0;
        end
    end

    // Slow oscillators pass through, their duty is not touched
    assign nxt_sysclk = clk_bus.fast ? corr_ff : osc_q_ff;

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            sysclk_ff <= 1'b0;
            rise_ff <= 1'b0;
        end
        else
        begin
            sysclk_ff <= nxt_sysclk;
            rise_ff <= nxt_sysclk & ~sysclk_ff;
        end
    end

    assign clk_bus.fast = (period_ff <= SCG_PER_W'(SCG_FAST_PERIOD_CYC));
    assign clk_bus.sysclk = sysclk_ff;
    assign clk_bus.sysclk_rise = rise_ff;

    a_duty_start_high: assert property (@(posedge core_clk) disable iff (reset)
        osc_rise |=> corr_ff)
        else $error("corrected clock did not go high on oscillator edge");
endmodule

// File: core/scg_pkg.sv
// Constants and types shared by the system clock generator files
package scg_pkg;
    // Register index as printed; byte address is four times the index
    localparam logic [15:0] SCG_CTL_INDEX = 16'hff3a;
    localparam logic [17:0] SCG_CTL_ADDR = {SCG_CTL_INDEX, 2'b00};
    localparam int SCG_ADDR_W = 18;
    // Field layout of system_clock_control
    localparam int SCG_PIN_DIS_BIT = 7;
    localparam int SCG_RSV6_BIT = 6;
    localparam int SCG_SEL_LSB = 0;
    localparam int SCG_SEL_W = 3;
    localparam logic [7:0] SCG_CTL_RESET = 8'h00;
    // Writable bits: 7, 6 and 2..0
    localparam logic [7:0] SCG_CTL_WMASK = 8'hc7;
    // Selection codes
    localparam logic [2:0] SCG_SEL_FULL = 3'h0;
    localparam logic [2:0] SCG_SEL_MAX = 3'h5;
    localparam int SCG_NDIV = 5;
    // Duty correction threshold
    localparam int SCG_CLK_MHZ = 50;
    localparam int SCG_FAST_MHZ = 5;
    // Longest oscillator period, in core cycles, still counted as fast
    localparam int SCG_FAST_PERIOD_CYC = SCG_CLK_MHZ / SCG_FAST_MHZ;
    localparam int SCG_PER_W = 8;
    localparam logic [SCG_PER_W-1:0] SCG_PER_MAX = 8'hff;

    typedef enum logic [1:0] {
        SCG_NORMAL,
        SCG_SLEEP,
        SCG_SW_STANDBY,
        SCG_HW_STANDBY
    } scg_mode_t;
endpackage

// File: core/scg_top.sv
// System clock generator: duty stage, divider, bus master select, register
//
// Operation
// - Control register clears to zero on reset and during hardware standby.
// - Control register keeps its value through software standby entry and exit.
// - Output disable low: pin follows clock, high in software standby, floats in hardware.
// - Output disable high: pin held high, floats in hardware standby.
// - Bit 6 reads back what was written; software writes only zero.
// - Bits 5 to 3 read zero and ignore writes.
// - Select code zero feeds the bus master the undivided system clock.
// - Codes one to five feed the system clock divided by 2,4,8,16,32.
// - Five divided clocks run from the system clock and halt in software and hardware standby.
// - Bus master clock source chosen by the current select field; held high in either standby.
// - At five megahertz or more the oscillator duty is corrected.
// - Peripheral clock stays undivided while the bus master runs divided.
`timescale 1ns/10ps
module scg_top
    import scg_pkg::*;
(
    input wire logic core_clk, // 50 MHz logic clock
    input wire logic reset, // Synchronous reset, active high
    input wire logic osc_clk, // Oscillator or external clock level
    input wire logic sleep_mode, // CPU in sleep
    input wire logic sw_standby, // Software standby in effect
    input wire logic hw_standby, // Hardware standby in effect
    input wire logic [SCG_ADDR_W-1:0] avs_address, // Byte address
    input wire logic avs_read, // Read request
    input wire logic avs_write, // Write request
    input wire logic [31:0] avs_writedata, // Write data
    input wire logic [3:0] avs_byteenable, // Byte lanes
    output logic [31:0] avs_readdata, // Read data
    output logic avs_waitrequest, // Stall, low at completion
    output logic sysclk_pin_level, // System clock pin level
    output logic sysclk_pin_oe, // System clock pin drive enable
    output logic bus_master_clk, // Clock for the bus master
    output logic periph_clk, // Undivided clock for other modules
    output logic sysclk_fast // Duty correction active
);
    scg_clk_if clk_bus ();

    scg_duty u_duty
    (
        .core_clk(core_clk),
        .reset(reset),
        .osc_clk(osc_clk),
        .clk_bus(clk_bus.duty)
    );

    scg_divider u_divider
    (
        .core_clk(core_clk),
        .reset(reset),
        .clk_bus(clk_bus.divider)
    );

    function automatic logic sel_clock(input logic [2:0] sel, input logic full, input logic [4:0] div);
        logic r;
        r = 1'b1;
        case (sel)
            3'h0: r = full;
            3'h1: r = div[0];
            3'h2: r = div[1];
            3'h3: r = div[2];
            3'h4: r = div[3];
            3'h5: r = div[4];
            default: r = 1'b1;
        endcase
        return r;
    endfunction

    logic [7:0] ctl_ff;
    logic ack_ff;
    logic [31:0] rdata_ff;
    scg_mode_t mode_ff;
    scg_mode_t nxt_mode;
    logic pin_ff;
    logic pin_oe_ff;
    logic bm_clk_ff;
    logic req;
    logic hit;
    logic wr_take;
    logic pin_disable;
    logic [2:0] sel;
    logic running;

    assign req = avs_read | avs_write;
    assign hit = (avs_address == SCG_CTL_ADDR);
    assign wr_take = avs_write & ack_ff & hit & avs_byteenable[0];
    assign pin_disable = ctl_ff[SCG_PIN_DIS_BIT];
    assign sel = ctl_ff[SCG_SEL_LSB +: SCG_SEL_W];
    assign running = (mode_ff == SCG_NORMAL) || (mode_ff == SCG_SLEEP);

    // Hardware standby outranks software standby outranks sleep
    always_comb
    begin
        nxt_mode = SCG_NORMAL;
        if (hw_standby)
            nxt_mode = SCG_HW_STANDBY;
        else if (sw_standby)
            nxt_mode = SCG_SW_STANDBY;
        else if (sleep_mode)
            nxt_mode = SCG_SLEEP;
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
            mode_ff <= SCG_NORMAL;
        else
            mode_ff <= nxt_mode;
    end

    // One wait state on every access, mapped or not
    always_ff @(posedge core_clk)
    begin
        if (reset)
            ack_ff <= 1'b0;
        else
            ack_ff <= req & ~ack_ff;
    end

    assign avs_waitrequest = req & ~ack_ff;

    // Cleared by reset and hardware standby
    // Software standby leaves the register alone
    always_ff @(posedge core_clk)
    begin
        if (reset || hw_standby)
            ctl_ff <= SCG_CTL_RESET;
        else if (wr_take)
            ctl_ff <= avs_writedata[7:0] & SCG_CTL_WMASK;
    end

    // Read data settles during the wait cycle; unmapped reads return zero
    always_ff @(posedge core_clk)
    begin
        if (reset)
            rdata_ff <= '0;
        else if (avs_read && !ack_ff)
            rdata_ff <= hit ? {24'h000000, ctl_ff & SCG_CTL_WMASK} : 32'h00000000;
    end

    assign avs_readdata = rdata_ff;

    // Pin level and drive by mode and disable bit
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            pin_ff <= 1'b0;
            pin_oe_ff <= 1'b1;
        end
        else
        begin
            case (nxt_mode)
                SCG_NORMAL, SCG_SLEEP:
                begin
                    pin_ff <= pin_disable ? 1'b1 : clk_bus.sysclk;
                    pin_oe_ff <= 1'b1;
                end
                SCG_SW_STANDBY:
                begin
                    pin_ff <= 1'b1;
                    pin_oe_ff <= 1'b1;
                end
                SCG_HW_STANDBY:
                begin
                    pin_ff <= 1'b1;
                    pin_oe_ff <= 1'b0;
                end
                default:
                begin
                    pin_ff <= 1'b1;
                    pin_oe_ff <= 1'b0;
                end
            endcase
        end
    end

    assign sysclk_pin_level = pin_ff;
    assign sysclk_pin_oe = pin_oe_ff;

    // Divider halts in standby so it restarts in phase with the oscillator
    assign clk_bus.run = running;

    // Source picked by select field, held high in standby
    always_ff @(posedge core_clk)
    begin
        if (reset)
            bm_clk_ff <= 1'b0;
        else if (!running)
            bm_clk_ff <= 1'b1;
        else
            bm_clk_ff <= sel_clock(sel, clk_bus.sysclk, clk_bus.div);
    end

    assign bus_master_clk = bm_clk_ff;

    // Other modules never see the divided clock
    assign periph_clk = clk_bus.sysclk;
    assign sysclk_fast = clk_bus.fast;

    a_ctl_hw_clear: assert property (@(posedge core_clk)
        hw_standby |=> ctl_ff == SCG_CTL_RESET)
        else $error("control register not cleared in hardware standby");

    a_ctl_reset_clear: assert property (@(posedge core_clk)
        reset |=> ctl_ff == SCG_CTL_RESET)
        else $error("control register not cleared by reset");

    a_ctl_sw_keep: assert property (@(posedge core_clk) disable iff (reset)
        (sw_standby && !hw_standby && !wr_take) |=> $stable(ctl_ff))
        else $error("control register changed in software standby");

    a_pin_follows_clk: assert property (@(posedge core_clk) disable iff (reset)
        (!hw_standby && !sw_standby && !pin_disable) |=> (sysclk_pin_level == $past(clk_bus.sysclk)) && sysclk_pin_oe)
        else $error("pin does not follow system clock");

    a_pin_sleep_clk: assert property (@(posedge core_clk) disable iff (reset)
        (sleep_mode && !sw_standby && !hw_standby && !pin_disable) |=> sysclk_pin_level == $past(clk_bus.sysclk))
        else $error("pin does not follow clock in sleep");

    a_pin_drive_on: assert property (@(posedge core_clk) disable iff (reset)
        !hw_standby |=> sysclk_pin_oe)
        else $error("pin not driven outside hardware standby");

    a_pin_hw_float: assert property (@(posedge core_clk) disable iff (reset)
        hw_standby |=> !sysclk_pin_oe)
        else $error("pin driven in hardware standby");

    a_pin_held_high: assert property (@(posedge core_clk) disable iff (reset)
        (!hw_standby && (pin_disable || sw_standby)) |=> sysclk_pin_level && sysclk_pin_oe)
        else $error("pin not held high");

    a_disable_takes_write: assert property (@(posedge core_clk) disable iff (reset)
        (wr_take && !hw_standby) |=> pin_disable == $past(avs_writedata[SCG_PIN_DIS_BIT]))
        else $error("output disable bit did not take written value");

    a_rsv6_readback: assert property (@(posedge core_clk) disable iff (reset)
        (wr_take && !hw_standby) |=> ctl_ff[SCG_RSV6_BIT] == $past(avs_writedata[SCG_RSV6_BIT]))
        else $error("bit 6 did not take written value");

    a_read_ctl_value: assert property (@(posedge core_clk) disable iff (reset)
        (avs_read && !avs_waitrequest && hit) |-> avs_readdata[7:0] == ($past(ctl_ff) & SCG_CTL_WMASK))
        else $error("read data differs from control register");

    a_rsv_read_zero: assert property (@(posedge core_clk) disable iff (reset)
        (avs_read && !avs_waitrequest) |-> avs_readdata[5:3] == 3'h0 && ctl_ff[5:3] == 3'h0)
        else $error("reserved bits not zero");

    a_rsv_write_drop: assert property (@(posedge core_clk) disable iff (reset)
        (wr_take && !hw_standby) |=> ctl_ff[5:3] == 3'h0)
        else $error("reserved bits took written value");

    a_read_upper_zero: assert property (@(posedge core_clk) disable iff (reset)
        (avs_read && !avs_waitrequest) |-> avs_readdata[31:8] == 24'h000000)
        else $error("upper read data not zero");

    a_unmapped_zero: assert property (@(posedge core_clk) disable iff (reset)
        (avs_read && !avs_waitrequest && !hit) |-> avs_readdata == 32'h00000000)
        else $error("unmapped read not zero");

    a_bm_full_speed: assert property (@(posedge core_clk) disable iff (reset)
        (running && sel == SCG_SEL_FULL) |=> bus_master_clk == $past(clk_bus.sysclk))
        else $error("bus master clock not undivided");

    a_bm_divided: assert property (@(posedge core_clk) disable iff (reset)
        (running && sel != SCG_SEL_FULL && sel <= SCG_SEL_MAX)
        |=> bus_master_clk == $past(clk_bus.div[sel - 3'h1]))
        else $error("bus master clock wrong divided source");

    a_div_halt: assert property (@(posedge core_clk) disable iff (reset)
        !running |=> $stable(clk_bus.div))
        else $error("divider moved while halted");

    a_sel_takes_write: assert property (@(posedge core_clk) disable iff (reset)
        (wr_take && !hw_standby) |=> sel == $past(avs_writedata[SCG_SEL_LSB +: SCG_SEL_W]))
        else $error("select field did not take written value");

    a_periph_undivided: assert property (@(posedge core_clk) disable iff (reset)
        periph_clk == clk_bus.sysclk)
        else $error("peripheral clock divided");
endmodule

// File: testbench/scg_osc_model.sv
// Oscillator source model driving the clock input of the generator
`timescale 1ns/10ps
module scg_osc_model
(
    input wire logic core_clk, // Core clock
    input wire logic [7:0] high_cyc, // High phase, core cycles
    input wire logic [7:0] low_cyc, // Low phase, core cycles
    input wire logic standby, // Either standby in effect
    output logic osc_clk // Clock level
);
    logic osc_ff = 1'b0;
    logic [7:0] cnt_ff = 8'h00;
    assign osc_clk = osc_ff;
    always_ff @(posedge core_clk)
    begin
        if (standby)
        begin
            osc_ff <= 1'b1;
            cnt_ff <= 8'h00;
        end
        else if (cnt_ff + 8'h01 >= (osc_ff ? high_cyc : low_cyc))
        begin
            osc_ff <= !osc_ff;
            cnt_ff <= 8'h00;
        end
        else
        begin
            cnt_ff <= cnt_ff + 8'h01;
        end
    end
endmodule

// File: testbench/scg_top_tb.sv
// Self-checking bench for the system clock generator
`timescale 1ns/10ps
module scg_top_tb
    import scg_pkg::*;
;
    logic core_clk, reset, osc_clk, sleep_mode, sw_standby, hw_standby, avs_read, avs_write;
    logic [SCG_ADDR_W-1:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata;
    logic [3:0] avs_byteenable;
    logic avs_waitrequest, sysclk_pin_level, sysclk_pin_oe, bus_master_clk, periph_clk, sysclk_fast;
    logic [7:0] high_cyc, low_cyc, q;
    int err_count, samples_checked, bm_r, pc_r, pc_h, pin_t, pin_h, oe_l;

    scg_top i_scg_top (.core_clk(core_clk), .reset(reset), .osc_clk(osc_clk), .sleep_mode(sleep_mode),
        .sw_standby(sw_standby), .hw_standby(hw_standby), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .sysclk_pin_level(sysclk_pin_level),
        .sysclk_pin_oe(sysclk_pin_oe), .bus_master_clk(bus_master_clk), .periph_clk(periph_clk),
        .sysclk_fast(sysclk_fast));
    scg_osc_model i_scg_osc_model (.core_clk(core_clk), .high_cyc(high_cyc), .low_cyc(low_cyc),
        .standby(sw_standby | hw_standby), .osc_clk(osc_clk));

    initial
    begin
        core_clk = 1'b0;
        forever #10 core_clk = !core_clk;
    end

    task end_sim;
        $display("mismatches %0d comparisons %0d", err_count, samples_checked);
        if (err_count == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task near(input int got, input int exp, input int tol);
        chk((got >= exp - tol && got <= exp + tol) ? exp : got, exp);
    endtask

    // One Avalon access; request held until waitrequest is sampled low at a rising edge
    task bus(input logic wr, input logic [17:0] a, input logic [7:0] d, input logic [3:0] be);
        int n;
        @(posedge core_clk);
        avs_address <= a;
        avs_writedata <= {24'h000000, d};
        avs_byteenable <= be;
        avs_write <= wr;
        avs_read <= !wr;
        n = 0;
        do
        begin
            @(posedge core_clk);
            n++;
        end
        while (avs_waitrequest !== 1'b0);
        // One wait state, then completion
        chk(n, 2);
        q = avs_readdata[7:0];
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask

    // Counts edges and levels of the clock outputs over n cycles
    task meas(input int n);
        logic bm, pc, pin;
        bm_r = 0;
        pc_r = 0;
        pc_h = 0;
        pin_t = 0;
        pin_h = 0;
        oe_l = 0;
        @(negedge core_clk);
        bm = bus_master_clk;
        pc = periph_clk;
        pin = sysclk_pin_level;
        repeat (n)
        begin
            @(negedge core_clk);
            bm_r += (bus_master_clk && !bm);
            pc_r += (periph_clk && !pc);
            pc_h += periph_clk;
            pin_t += (sysclk_pin_level != pin);
            pin_h += sysclk_pin_level;
            oe_l += !sysclk_pin_oe;
            bm = bus_master_clk;
            pc = periph_clk;
            pin = sysclk_pin_level;
        end
    endtask

    task t_reset;
        bus(1'b0, SCG_CTL_ADDR, 8'h00, 4'h1);
        chk(q, SCG_CTL_RESET); // value after reset
        meas(64);
        chk(pin_t > 0 && oe_l == 0, 1); // pin follows clock
    endtask

    task t_regs;
        bus(1'b1, SCG_CTL_ADDR, 8'hfd, 4'h1);
        bus(1'b0, SCG_CTL_ADDR, 8'h00, 4'h1);
        chk(q, 8'hc5); // bit 6 kept, 5..3 zero
        bus(1'b1, SCG_CTL_ADDR + 18'h4, 8'h00, 4'h1);
        bus(1'b1, SCG_CTL_ADDR, 8'h00, 4'he);
        bus(1'b0, SCG_CTL_ADDR + 18'h4, 8'h00, 4'h1);
        chk(q, 8'h00); // unmapped reads zero
        bus(1'b0, SCG_CTL_ADDR, 8'h00, 4'h1);
        chk(q, 8'hc5); // ignored writes leave value
    endtask

    task t_sel;
        int k;
        for (k = 0; k <= SCG_SEL_MAX; k++)
        begin
            bus(1'b1, SCG_CTL_ADDR, 8'(k), 4'h1);
            meas(1024);
            near(bm_r, 128 >> k, 1); // divide ratio
            near(pc_r, 128, 1); // peripheral clock undivided
        end
    endtask

    task t_duty;
        high_cyc <= 8'h01;
        low_cyc <= 8'h07;
        repeat (64) @(posedge core_clk);
        meas(1024);
        chk(sysclk_fast, 1'b1); // fast oscillator seen
        near(pc_h, 512, 32); // corrected duty near half
        high_cyc <= 8'h02;
        low_cyc <= 8'h12;
        repeat (64) @(posedge core_clk);
        meas(400);
        chk(sysclk_fast, 1'b0); // slow oscillator passes
        near(pc_r, 20, 1); // slow clock keeps its rate
        high_cyc <= 8'h04;
        low_cyc <= 8'h04;
    endtask

    task t_pin;
        int p, m;
        for (p = 0; p < 2; p++)
        begin
            bus(1'b1, SCG_CTL_ADDR, {p[0], 7'h01}, 4'h1);
            for (m = 0; m < 4; m++)
            begin
                @(posedge core_clk);
                sleep_mode <= (m == 1);
                sw_standby <= (m == 2);
                hw_standby <= (m == 3);
                repeat (8) @(posedge core_clk);
                meas(64);
                if (m == 3)
                    chk(oe_l, 64); // pin floats
                else if (p == 0 && m < 2)
                    chk(pin_t > 0 && oe_l == 0, 1); // pin follows clock
                else
                    chk(pin_h == 64 && oe_l == 0, 1); // pin held high
                @(posedge core_clk);
                sleep_mode <= 1'b0;
                sw_standby <= 1'b0;
                hw_standby <= 1'b0;
                repeat (8) @(posedge core_clk);
                bus(1'b0, SCG_CTL_ADDR, 8'h00, 4'h1);
                if (m == 3)
                    chk(q, SCG_CTL_RESET); // cleared by hardware standby
                else
                    chk(q, {p[0], 7'h01}); // kept through standby
            end
        end
    endtask

    initial
    begin
        #(20 * 60000);
        err_count++;
        end_sim;
    end

    initial
    begin
        err_count = 0;
        samples_checked = 0;
        reset = 1'b1;
        sleep_mode = 1'b0;
        sw_standby = 1'b0;
        hw_standby = 1'b0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = '0;
        avs_writedata = 32'h00000000;
        avs_byteenable = 4'h0;
        high_cyc = 8'h04;
        low_cyc = 8'h04;
        repeat (3) @(posedge core_clk);
        reset <= 1'b0;
        t_reset;
        t_regs;
        t_sel;
        t_duty;
        t_pin;
        end_sim;
    end
endmodule
